/* File: rtl/acr_map.svh */
// Register map, field positions, reset values and timing counts of the converter block
// Operation
// R1: Conversion loads high result; unused bits zero
// R2: Conversion loads low result; read-only, resets zero
// R3: 10-bit: high read blocks transfers until low read
// R4: Conversions during interlock are discarded, not queued
// R5: 8-bit mode has no read interlock
// R6: Low-power bit selects reduced-power converter setting
// R7: Divider field divides input clock 1/2/4/8
// R8: Async off: select 1 bus, 0 alternate
// R9: Mode field: 8-bit, 10-bit, reserved, triggered
// R10: Reset sets 8-bit write-triggered mode
// R11: Result rounded to selected width, half LSB
// R12: Long-sample bit: 23.5 else 3.5 cycles; the code rounds these up to 24 and 4 whole cycles
// R13: Async on: async source, gated, runs in stop
// R14: Async off: select bit chooses, stop halts
// R15: Clock configuration write ends continuous conversion
// R16: Low read or status write clears done
// R17: Status write aborts, restarts unless channel all ones; in triggered mode the code aborts only on an all-ones write
// R18: Triggered mode: synced rising edge starts, busy ignores
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// Register indices; the byte address is four times the index
`define ACR_IDX_STATUS_CTRL    8'h3c
`define ACR_IDX_RESULT_HIGH    8'h3d
`define ACR_IDX_RESULT_LOW     8'h3e
`define ACR_IDX_CLOCK_CFG      8'h3f
`define ACR_IDX_IRQ_STATUS     8'h40
`define ACR_IDX_IRQ_MASK       8'h41

// Status and control fields
`define ACR_SC_DONE_BIT        7
`define ACR_SC_IRQ_EN_BIT      6
`define ACR_SC_CONT_BIT        5
`define ACR_CHANNEL_OFF        5'h1f

// Clock configuration fields
`define ACR_CK_LOW_POWER_BIT   7
`define ACR_CK_DIV_LSB         5
`define ACR_CK_INSEL_BIT       4
`define ACR_CK_MODE_LSB        2
`define ACR_CK_LONG_BIT        1
`define ACR_CK_ASYNC_BIT       0

// Reset values
`define ACR_RST_STATUS_CTRL    8'h1f
`define ACR_RST_CLOCK_CFG      8'h00
`define ACR_RST_RESULT         8'h00

// Interrupt status bits
`define ACR_IRQ_DONE_BIT       0
`define ACR_IRQ_LOST_BIT       1

// Sample phase in half converter cycles, and whole cycles rounded up
`define ACR_SAMPLE_SHORT_HALF  7
`define ACR_SAMPLE_LONG_HALF   47
`define ACR_SAMPLE_SHORT_CYC   ((`ACR_SAMPLE_SHORT_HALF + 1) / 2)
`define ACR_SAMPLE_LONG_CYC    ((`ACR_SAMPLE_LONG_HALF + 1) / 2)

`endif

/* File: rtl/acr_pkg.sv */
// Types shared by the converter block
package acr_pkg;
   typedef enum logic [1:0] {
      ACR_MODE_8BIT  = 2'b00,
      ACR_MODE_10BIT = 2'b01,
      ACR_MODE_RSVD  = 2'b10,
      ACR_MODE_TRIG  = 2'b11
   } acr_mode_e;

   typedef enum logic [1:0] {
      ACR_ST_IDLE    = 2'b00,
      ACR_ST_SAMPLE  = 2'b01,
      ACR_ST_CONVERT = 2'b10
   } acr_state_e;
endpackage

/* File: rtl/acr_top.sv */
// Converter result registers, clock configuration and conversion sequencer
`timescale 1ns/1ps
`include "acr_map.svh"

module acr_top
   import acr_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input  wire logic              CLK_SYS_I,
   input  wire logic              SRST_I,
   // AXI4-Lite write address, data and response
   input  wire logic [ADDR_W-1:0] AWADDR_I,
   input  wire logic              AWVALID_I,
   output logic                   AWREADY_O,
   input  wire logic [31:0]       WDATA_I,
   input  wire logic [3:0]        WSTRB_I,
   input  wire logic              WVALID_I,
   output logic                   WREADY_O,
   output logic [1:0]             BRESP_O,
   output logic                   BVALID_O,
   input  wire logic              BREADY_I,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] ARADDR_I,
   input  wire logic              ARVALID_I,
   output logic                   ARREADY_O,
   output logic [31:0]            RDATA_O,
   output logic [1:0]             RRESP_O,
   output logic                   RVALID_O,
   input  wire logic              RREADY_I,
   // Clock sources and trigger pins
   input  wire logic              ALT_CLK_I,
   input  wire logic              ASYNC_CLK_I,
   input  wire logic              TRIG_I,
   input  wire logic              STOP_MODE_I,
   // Analog front end
   input  wire logic [11:0]       ANALOG_CODE_I,
   output logic [4:0]             CHANNEL_O,
   output logic                   LOW_POWER_O,
   output logic                   ASYNC_GEN_EN_O,
   output logic                   BUSY_O,
   // Interrupt
   output logic                   IRQ_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a change counts once stages two and three agree
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic [2:0] sync3_reg;
   logic [2:0] pin_lvl_reg;
   logic [2:0] pin_rise;
   logic [2:0] pin_raw;

   assign pin_raw = {TRIG_I, ASYNC_CLK_I, ALT_CLK_I};

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sync
         always_ff @(posedge CLK_SYS_I)
         begin
            if (SRST_I)
            begin
               sync1_reg[g]   <= 1'b0;
               sync2_reg[g]   <= 1'b0;
               sync3_reg[g]   <= 1'b0;
               pin_lvl_reg[g] <= 1'b0;
            end
            else
            begin
               sync1_reg[g] <= pin_raw[g];
               sync2_reg[g] <= sync1_reg[g];
               sync3_reg[g] <= sync2_reg[g];
               if (sync2_reg[g] == sync3_reg[g])
                  pin_lvl_reg[g] <= sync3_reg[g];
            end
         end
         assign pin_rise[g] = (sync2_reg[g] == sync3_reg[g]) && sync3_reg[g]
                              && !pin_lvl_reg[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] status_ctrl_reg;
   logic [7:0] clock_cfg_reg;
   logic [7:0] result_high_reg;
   logic [7:0] result_low_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic       done_flag_reg;
   logic       interlock_reg;

   acr_mode_e  mode;
   logic [1:0] clock_divide_sel;
   logic       async_clock_enable;
   logic       input_clock_sel;
   logic       long_sample_sel;
   logic       continuous;
   logic [4:0] channel_select;

   assign mode               = acr_mode_e'(clock_cfg_reg[`ACR_CK_MODE_LSB +: 2]);
   assign clock_divide_sel   = clock_cfg_reg[`ACR_CK_DIV_LSB +: 2];
   assign async_clock_enable = clock_cfg_reg[`ACR_CK_ASYNC_BIT];
   assign input_clock_sel    = clock_cfg_reg[`ACR_CK_INSEL_BIT];
   assign long_sample_sel    = clock_cfg_reg[`ACR_CK_LONG_BIT];
   assign continuous         = status_ctrl_reg[`ACR_SC_CONT_BIT];
   assign channel_select     = status_ctrl_reg[4:0];

   // Register index from a byte address; misaligned addresses map nowhere
   function automatic logic [8:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = (addr[1:0] != 2'b00) ? 9'h1ff : 9'(addr[ADDR_W-1:2]);
   endfunction

   function automatic logic idx_hit(input logic [8:0] idx, input logic [7:0] want);
      idx_hit = (idx == {1'b0, want});
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data taken in either order
   logic              aw_held_reg;
   logic              w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [7:0]        wdata_reg;
   logic              wstrb0_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              wr_go;
   logic [8:0]        wr_idx;
   logic              wr_sc;
   logic              wr_ck;
   logic              wr_map;

   assign AWREADY_O = !aw_held_reg && !bvalid_reg;
   assign WREADY_O  = !w_held_reg && !bvalid_reg;
   assign BVALID_O  = bvalid_reg;
   assign BRESP_O   = bresp_reg;
   assign wr_go     = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_idx    = reg_index(awaddr_reg);
   assign wr_map    = idx_hit(wr_idx, `ACR_IDX_STATUS_CTRL) || idx_hit(wr_idx, `ACR_IDX_CLOCK_CFG)
                      || idx_hit(wr_idx, `ACR_IDX_IRQ_STATUS) || idx_hit(wr_idx, `ACR_IDX_IRQ_MASK)
                      || idx_hit(wr_idx, `ACR_IDX_RESULT_HIGH)
                      || idx_hit(wr_idx, `ACR_IDX_RESULT_LOW);
   // Writes with byte lane 0 disabled change nothing, since every register is at most one byte wide
   assign wr_sc     = wr_go && wstrb0_reg && idx_hit(wr_idx, `ACR_IDX_STATUS_CTRL);
   assign wr_ck     = wr_go && wstrb0_reg && idx_hit(wr_idx, `ACR_IDX_CLOCK_CFG);

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= 8'h00;
         wstrb0_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'b00;
      end
      else
      begin
         if (AWVALID_I && AWREADY_O)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= AWADDR_I;
         end
         if (WVALID_I && WREADY_O)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= WDATA_I[7:0];
            wstrb0_reg <= WSTRB_I[0];
         end
         if (wr_go)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_map ? 2'b00 : 2'b10;
         end
         else if (bvalid_reg && BREADY_I)
            bvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path; result reads act on the interlock when the address is taken
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        rd_go;
   logic [8:0]  rd_idx;
   logic        rd_high;
   logic        rd_low;

   assign ARREADY_O = !rvalid_reg;
   assign RVALID_O  = rvalid_reg;
   assign RDATA_O   = rdata_reg;
   assign RRESP_O   = rresp_reg;
   assign rd_go     = ARVALID_I && !rvalid_reg;
   assign rd_idx    = reg_index(ARADDR_I);
   assign rd_high   = rd_go && idx_hit(rd_idx, `ACR_IDX_RESULT_HIGH);
   assign rd_low    = rd_go && idx_hit(rd_idx, `ACR_IDX_RESULT_LOW);

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= 2'b00;
      end
      else if (rd_go)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= 2'b00;
         rdata_reg  <= 32'h0000_0000;
         if (idx_hit(rd_idx, `ACR_IDX_STATUS_CTRL))
            rdata_reg[7:0] <= {done_flag_reg, status_ctrl_reg[6:0]};
         else if (idx_hit(rd_idx, `ACR_IDX_RESULT_HIGH))
            rdata_reg[7:0] <= result_high_reg;
         else if (idx_hit(rd_idx, `ACR_IDX_RESULT_LOW))
            rdata_reg[7:0] <= result_low_reg;
         else if (idx_hit(rd_idx, `ACR_IDX_CLOCK_CFG))
            rdata_reg[7:0] <= clock_cfg_reg;
         else if (idx_hit(rd_idx, `ACR_IDX_IRQ_STATUS))
            rdata_reg[1:0] <= irq_status_reg;
         else if (idx_hit(rd_idx, `ACR_IDX_IRQ_MASK))
            rdata_reg[1:0] <= irq_mask_reg;
         else
            rresp_reg <= 2'b10;
      end
      else if (RREADY_I)
         rvalid_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic stop_halt;
   assign stop_halt = STOP_MODE_I && !async_clock_enable;   // see R14

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         clock_cfg_reg <= `ACR_RST_CLOCK_CFG;   // see R10
      else if (wr_ck)
         clock_cfg_reg <= wdata_reg;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         status_ctrl_reg <= `ACR_RST_STATUS_CTRL;
      else if (wr_sc)
         status_ctrl_reg <= {1'b0, wdata_reg[6:0]};
      else if (wr_ck || stop_halt)
         status_ctrl_reg[`ACR_SC_CONT_BIT] <= 1'b0;   // see R15
   end

   assign CHANNEL_O   = channel_select;
   assign LOW_POWER_O = clock_cfg_reg[`ACR_CK_LOW_POWER_BIT];   // see R6

   ////////////////////////////////////////////////////////////////////////////////
   // Converter clock: selected source divided by 1, 2, 4 or 8
   acr_state_e state_reg;
   logic       src_tick;
   logic [2:0] div_cnt_reg;
   logic [2:0] div_last;
   logic       conv_tick;

   always_comb
   begin
      if (async_clock_enable)
         src_tick = pin_rise[1];            // see R13
      else if (input_clock_sel)
         src_tick = 1'b1;                   // see R8
      else
         src_tick = pin_rise[0];            // see R8
   end

   assign div_last  = 3'((4'd1 << clock_divide_sel) - 4'd1);   // see R7
   assign conv_tick = src_tick && (div_cnt_reg == div_last);

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I || state_reg == ACR_ST_IDLE || (wr_sc && mode != ACR_MODE_TRIG))
         div_cnt_reg <= 3'd0;
      else if (src_tick)
         div_cnt_reg <= conv_tick ? 3'd0 : div_cnt_reg + 3'd1;
   end

   // Async generator runs only while a conversion is in progress
   assign ASYNC_GEN_EN_O = async_clock_enable && (state_reg != ACR_ST_IDLE);   // see R13
   assign BUSY_O         = (state_reg != ACR_ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   logic [4:0]  cnt_reg;
   logic [11:0] raw_reg;
   logic        start;
   logic        finish;
   logic        ten_bit;
   logic [4:0]  sample_len;
   logic [4:0]  convert_len;

   assign ten_bit     = (mode != ACR_MODE_8BIT);   // see R9
   assign sample_len  = long_sample_sel ? 5'(`ACR_SAMPLE_LONG_CYC)
                                        : 5'(`ACR_SAMPLE_SHORT_CYC);   // see R12
   assign convert_len = ten_bit ? 5'd10 : 5'd8;
   // A trigger is taken only from idle, so one arriving mid-conversion is dropped
   assign start = (wr_sc && wdata_reg[4:0] != `ACR_CHANNEL_OFF && mode != ACR_MODE_TRIG
                   && !stop_halt)                                                 // see R17
                  || (mode == ACR_MODE_TRIG && pin_rise[2] && state_reg == ACR_ST_IDLE
                      && channel_select != `ACR_CHANNEL_OFF && !stop_halt);      // see R18
   assign finish = (state_reg == ACR_ST_CONVERT) && conv_tick && (cnt_reg == convert_len - 5'd1);

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         state_reg <= ACR_ST_IDLE;
         cnt_reg   <= 5'd0;
         raw_reg   <= 12'h000;
      end
      else if (stop_halt || (wr_sc && wdata_reg[4:0] == `ACR_CHANNEL_OFF))
         state_reg <= ACR_ST_IDLE;                                               // see R14
      else if (start && (wr_sc || state_reg == ACR_ST_IDLE))
      begin
         state_reg <= ACR_ST_SAMPLE;                                             // see R17
         cnt_reg   <= 5'd0;
      end
      else if (conv_tick)
      begin
         case (state_reg)
            ACR_ST_SAMPLE:
            begin
               if (cnt_reg == sample_len - 5'd1)
               begin
                  state_reg <= ACR_ST_CONVERT;
                  cnt_reg   <= 5'd0;
                  raw_reg   <= ANALOG_CODE_I;
               end
               else
                  cnt_reg <= cnt_reg + 5'd1;
            end
            ACR_ST_CONVERT:
            begin
               if (finish)
               begin
                  state_reg <= (continuous && mode != ACR_MODE_TRIG) ? ACR_ST_SAMPLE
                                                                     : ACR_ST_IDLE;
                  cnt_reg   <= 5'd0;
               end
               else
                  cnt_reg <= cnt_reg + 5'd1;
            end
            default:
               state_reg <= ACR_ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Rounding of the raw sample to the selected width, saturating at full scale
   logic [10:0] round10;
   logic [8:0]  round8;
   logic [9:0]  code;

   assign round10 = 11'({1'b0, raw_reg[11:2]} + {10'd0, raw_reg[1]});     // see R11
   assign round8  = 9'({1'b0, raw_reg[11:4]} + {8'd0, raw_reg[3]});       // see R11
   always_comb
   begin
      if (ten_bit)
         code = round10[10] ? 10'h3ff : round10[9:0];
      else
         code = round8[8] ? 10'h0ff : {2'b00, round8[7:0]};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result registers and read interlock
   logic load;
   logic lost;
   // While locked, a finished result is dropped rather than queued
   assign load = finish && !interlock_reg;                                 // see R3
   assign lost = finish && interlock_reg;                                  // see R4

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         interlock_reg <= 1'b0;
      else if (rd_low || !ten_bit)
         interlock_reg <= 1'b0;                                            // see R5
      else if (rd_high)
         interlock_reg <= 1'b1;                                            // see R3
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         result_high_reg <= `ACR_RST_RESULT;
         result_low_reg  <= `ACR_RST_RESULT;                               // see R2
      end
      else if (load)
      begin
         result_high_reg <= {6'b00_0000, code[9:8]};                       // see R1
         result_low_reg  <= code[7:0];                                     // see R2
      end
   end

   // A new result wins over a clear in the same cycle
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         done_flag_reg <= 1'b0;
      else if (load)
         done_flag_reg <= 1'b1;
      else if (rd_low || wr_sc)
         done_flag_reg <= 1'b0;                                            // see R16
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt: sticky events, write one to clear, set wins over clear
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   assign irq_set = {lost, load};
   assign irq_clr = (wr_go && wstrb0_reg && idx_hit(wr_idx, `ACR_IDX_IRQ_STATUS))
                    ? wdata_reg[1:0] : 2'b00;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         irq_status_reg <= 2'b00;
      else
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
         irq_mask_reg <= 2'b00;
      else if (wr_go && wstrb0_reg && idx_hit(wr_idx, `ACR_IDX_IRQ_MASK))
         irq_mask_reg <= wdata_reg[1:0];
   end

   assign IRQ_O = |(irq_status_reg & irq_mask_reg);

endmodule // acr_top

/* File: bench/acr_top_checker.sv */
// Concurrent checks on the converter block ports
`timescale 1ns/1ps
//////////////////////////////
module acr_top_checker (
   // Clock and reset
   input wire logic        CLK_SYS_I,
   input wire logic        SRST_I,
   // Register bus
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic        BVALID_O,
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic        RVALID_O,
   input wire logic        RREADY_I,
   input wire logic [31:0] RDATA_O,
   // Converter status
   input wire logic        ASYNC_GEN_EN_O,
   input wire logic        BUSY_O,
   input wire logic [4:0]  CHANNEL_O,
   input wire logic        LOW_POWER_O,
   input wire logic        IRQ_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (SRST_I);

   sequence s_wr_taken;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence
   sequence s_rd_taken;
      ARVALID_I && ARREADY_O;
   endsequence

   chk_rd_latency: assert property (s_rd_taken |=> RVALID_O)
      else $error("read answer late");
   chk_wr_latency: assert property (s_wr_taken |-> ##[1:2] BVALID_O)
      else $error("write answer late");
   chk_rdata_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read answer dropped or changed");
   chk_ar_refused: assert property (ARREADY_O != RVALID_O)
      else $error("read accept while answer pending");
   chk_b_pend_block: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
      else $error("write accept while response pending");
   chk_upper_zero: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0)
      else $error("unused read bits not zero");
   chk_async_gate: assert property (ASYNC_GEN_EN_O |-> BUSY_O)
      else $error("async generator runs while idle");
   chk_reset_state: assert property ($fell(SRST_I) |->
      CHANNEL_O == 5'h1f && !LOW_POWER_O && !BUSY_O && !IRQ_O)
      else $error("state after reset wrong");
endmodule // acr_top_checker

bind acr_top acr_top_checker i_chk (
   .CLK_SYS_I, .SRST_I, .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O, .BVALID_O,
   .ARVALID_I, .ARREADY_O, .RVALID_O, .RREADY_I, .RDATA_O, .ASYNC_GEN_EN_O, .BUSY_O,
   .CHANNEL_O, .LOW_POWER_O, .IRQ_O
);

/* File: bench/testbench.sv */
// Register-level self-checking bench for the converter block
`timescale 1ns/1ps
//////////////////////////////
module testbench;
   localparam logic [11:0] A_SC = 12'h0f0;
   localparam logic [11:0] A_RH = 12'h0f4;
   localparam logic [11:0] A_RL = 12'h0f8;
   localparam logic [11:0] A_CK = 12'h0fc;
   localparam logic [11:0] A_IS = 12'h100;
   localparam logic [11:0] A_IM = 12'h104;
   logic        CLK_SYS_I = 0, SRST_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0;
   logic        ARVALID_I = 0, RREADY_I = 0, ALT_CLK_I = 0, ASYNC_CLK_I = 0;
   logic        TRIG_I = 0, STOP_MODE_I = 0;
   logic [11:0] AWADDR_I = '0, ARADDR_I = '0, ANALOG_CODE_I = '0;
   logic [31:0] WDATA_I = '0;
   logic [3:0]  WSTRB_I = 4'hf;
   logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
   logic        LOW_POWER_O, ASYNC_GEN_EN_O, BUSY_O, IRQ_O;
   logic [1:0]  BRESP_O, RRESP_O, r2;
   logic [31:0] RDATA_O;
   logic [4:0]  CHANNEL_O;
   logic [3:0]  div_cnt = '0;
   logic [7:0]  d;
   int          error_cnt = 0, total_checks = 0, cyc_cnt = 0, cyc, i;
   // Clock settings, analog codes, rounded results, converter ticks and divide ratio
   logic [7:0]  cfg_t [5] = '{8'h10, 8'h32, 8'h54, 8'h76, 8'h98};
   logic [11:0] code_t [5] = '{12'h7f8, 12'hfff, 12'h5fe, 12'hfff, 12'h005};
   logic [7:0]  hi_t [5] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
   logic [7:0]  lo_t [5] = '{8'h80, 8'hff, 8'h80, 8'hff, 8'h01};
   int          tk_t [5] = '{12, 32, 14, 34, 14};
   int          rt_t [5] = '{1, 2, 4, 8, 1};

   acr_top i_dut (.CLK_SYS_I, .SRST_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I,
      .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I,
      .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .ALT_CLK_I,
      .ASYNC_CLK_I, .TRIG_I, .STOP_MODE_I, .ANALOG_CODE_I, .CHANNEL_O, .LOW_POWER_O,
      .ASYNC_GEN_EN_O, .BUSY_O, .IRQ_O);

   always #20 CLK_SYS_I = ~CLK_SYS_I;

   // Slow sources: alternate at 1/8 and asynchronous at 1/16 of the system clock
   always @(posedge CLK_SYS_I)
   begin
      div_cnt <= div_cnt + 4'h1;
      ALT_CLK_I <= div_cnt[2];
      ASYNC_CLK_I <= div_cnt[3];
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   //////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] rexp);
      logic aw_t, w_t, b_t;
      logic [1:0] r;
      @(posedge CLK_SYS_I);
      AWADDR_I <= a;
      AWVALID_I <= 1'b1;
      WDATA_I <= {24'h0, v};
      WVALID_I <= 1'b1;
      BREADY_I <= 1'b1;
      b_t = 1'b0;
      for (int n = 0; n < 200 && !b_t; n++)
      begin
         @(negedge CLK_SYS_I);
         aw_t = AWVALID_I & AWREADY_O;
         w_t = WVALID_I & WREADY_O;
         b_t = BVALID_O;
         r = BRESP_O;
         @(posedge CLK_SYS_I);
         if (aw_t) AWVALID_I <= 1'b0;
         if (w_t) WVALID_I <= 1'b0;
      end
      BREADY_I <= 1'b0;
      chk($sformatf("bresp %h", a), r, rexp);
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] v, output logic [1:0] r);
      logic ar_t, r_t;
      @(posedge CLK_SYS_I);
      ARADDR_I <= a;
      ARVALID_I <= 1'b1;
      RREADY_I <= 1'b1;
      r_t = 1'b0;
      for (int n = 0; n < 200 && !r_t; n++)
      begin
         @(negedge CLK_SYS_I);
         ar_t = ARVALID_I & ARREADY_O;
         r_t = RVALID_O;
         v = RDATA_O[7:0];
         r = RRESP_O;
         @(posedge CLK_SYS_I);
         if (ar_t) ARVALID_I <= 1'b0;
      end
      RREADY_I <= 1'b0;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] v;
      logic [1:0] r;
      rd(a, v, r);
      chk($sformatf("reg %h", a), {r, v}, {2'b00, e});
   endtask

   // Busy time is counted from the end of the write, so it can read a little short
   task automatic conv(input logic [7:0] sc);
      wr(A_SC, sc, 2'b00);
      cyc = 0;
      for (int n = 0; n < 20 && BUSY_O !== 1'b1; n++) @(negedge CLK_SYS_I);
      while (BUSY_O === 1'b1 && cyc < 3000)
      begin
         @(negedge CLK_SYS_I);
         cyc++;
      end
   endtask

   task automatic span(input int e, input int s);
      chk("busy cycles", 32'(cyc >= e - 3 && cyc <= e + s), 32'h0000_0001);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge CLK_SYS_I);
      @(negedge CLK_SYS_I);
   endtask

   task automatic complete_run();
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   //////////////////////////////
   initial
   begin
      repeat (3) @(posedge CLK_SYS_I);
      SRST_I <= 1'b0;
      rdc(A_SC, 8'h1f);
      rdc(A_CK, 8'h00);
      rdc(A_RH, 8'h00);
      rdc(A_RL, 8'h00);
      wr(A_RL, 8'h55, 2'b00);
      rdc(A_RL, 8'h00);
      rd(12'h200, d, r2);
      chk("unmapped", {r2, d}, {2'b10, 8'h00});
      for (i = 0; i < 5; i++)
      begin
         wr(A_CK, cfg_t[i], 2'b00);
         ANALOG_CODE_I <= code_t[i];
         conv(8'h00);
         span(tk_t[i] * rt_t[i], rt_t[i] + 3);
         chk("low power", LOW_POWER_O, cfg_t[i][7]);
         rdc(A_SC, 8'h80);
         rdc(A_RH, hi_t[i]);
         rdc(A_RL, lo_t[i]);
         rdc(A_SC, 8'h00);
      end
      wr(A_CK, 8'h14, 2'b00);
      wr(A_IS, 8'h03, 2'b00);
      ANALOG_CODE_I <= 12'h5fe;
      conv(8'h00);
      rdc(A_RH, 8'h01);
      @(posedge CLK_SYS_I);
      ANALOG_CODE_I <= 12'h004;
      conv(8'h00);
      rdc(A_IS, 8'h03);
      rdc(A_RH, 8'h01);
      rdc(A_RL, 8'h80);
      conv(8'h00);
      rdc(A_RL, 8'h01);
      wr(A_CK, 8'h10, 2'b00);
      ANALOG_CODE_I <= 12'h7f8;
      conv(8'h00);
      rdc(A_RH, 8'h00);
      @(posedge CLK_SYS_I);
      ANALOG_CODE_I <= 12'h010;
      conv(8'h00);
      rdc(A_RL, 8'h01);
      wr(A_IS, 8'h03, 2'b00);
      wr(A_IM, 8'h01, 2'b00);
      chk("irq idle", IRQ_O, 1'b0);
      conv(8'h00);
      chk("irq set", IRQ_O, 1'b1);
      wr(A_IM, 8'h00, 2'b00);
      chk("irq masked", IRQ_O, 1'b0);
      wr(A_IM, 8'h01, 2'b00);
      chk("irq unmasked", IRQ_O, 1'b1);
      wr(A_IS, 8'h01, 2'b00);
      chk("irq cleared", IRQ_O, 1'b0);
      wr(A_SC, 8'h1f, 2'b00);
      wt(5);
      chk("off busy", BUSY_O, 1'b0);
      chk("off channel", CHANNEL_O, 5'h1f);
      wr(A_CK, 8'h76, 2'b00);
      wr(A_SC, 8'h00, 2'b00);
      wt(50);
      conv(8'h00);
      span(272, 11);
      wr(A_CK, 8'h10, 2'b00);
      wr(A_SC, 8'h20, 2'b00);
      wt(40);
      rd(A_SC, d, r2);
      chk("continuous on", d[5], 1'b1);
      wr(A_CK, 8'h10, 2'b00);
      rd(A_SC, d, r2);
      chk("continuous off", d[5], 1'b0);
      wt(20);
      wr(A_CK, 8'h76, 2'b00);
      wr(A_SC, 8'h00, 2'b00);
      wt(10);
      @(posedge CLK_SYS_I);
      STOP_MODE_I <= 1'b1;
      wt(5);
      chk("stop abort", BUSY_O, 1'b0);
      wr(A_CK, 8'h05, 2'b00);
      conv(8'h00);
      span(212, 12);
      chk("async gen idle", ASYNC_GEN_EN_O, 1'b0);
      rdc(A_SC, 8'h80);
      @(posedge CLK_SYS_I);
      STOP_MODE_I <= 1'b0;
      wr(A_CK, 8'h00, 2'b00);
      conv(8'h00);
      span(92, 4);
      wr(A_CK, 8'h1c, 2'b00);
      wr(A_SC, 8'h00, 2'b00);
      wt(5);
      chk("trig idle", BUSY_O, 1'b0);
      @(posedge CLK_SYS_I);
      TRIG_I <= 1'b1;
      wt(8);
      chk("trig start", BUSY_O, 1'b1);
      @(posedge CLK_SYS_I);
      TRIG_I <= 1'b0;
      wt(30);
      rdc(A_SC, 8'h80);
      complete_run();
   end
endmodule // testbench
